// file: src/mode_supply_ctrl_map.svh
// constants for the mode and supply control register bank and its spi frame
// assumes inclusion by bare name from the package and the design files
`ifndef MODE_SUPPLY_CTRL_MAP_SVH
`define MODE_SUPPLY_CTRL_MAP_SVH

// ****************************************
// frame layout
// ****************************************
`define FRAME_BITS          5'h10
`define FRAME_ADDR_W        7
`define FRAME_RW_BIT        7
`define FRAME_BYTE_BITS     5'h08

// ****************************************
// register map
// ****************************************
`define MS_CTRL_ADDR        7'h01
`define MS_CTRL_RESET       8'h00
`define MS_CTRL_RESTART_KEEP 8'h23

// ****************************************
// field positions
// ****************************************
`define MODE_HI             7
`define MODE_LO             6
`define THIRD_REG_BIT       5
`define SECOND_REG_HI       4
`define SECOND_REG_LO       3
`define OV_RESTART_BIT      2
`define THRESH_HI           1
`define THRESH_LO           0

// ****************************************
// mode codes and second regulator off code
// ****************************************
`define MODE_NORMAL         2'h0
`define MODE_SLEEP          2'h1
`define MODE_STOP           2'h2
`define MODE_SOFT_RESET     2'h3
`define SECOND_REG_OFF      2'h0

`endif

// file: src/mode_supply_ctrl_pkg.sv
// types shared by the spi frame receiver and the register bank
// assumes the map header is on the include path
`include "mode_supply_ctrl_map.svh"

package mode_supply_ctrl_pkg;

  typedef struct packed {
    logic [1:0] mode;
    logic       third_regulator_enable;
    logic [1:0] second_regulator_mode;
    logic       main_overvoltage_restart_en;
    logic [1:0] main_reset_threshold_sel;
  } ms_ctrl_t;

  typedef logic [15:0] frame_t;

endpackage

// file: src/spi_frame_if.sv
// carrier between the spi frame receiver and the register bank
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`include "mode_supply_ctrl_map.svh"

interface spi_frame_if;
  logic                               frame_done;
  mode_supply_ctrl_pkg::frame_t       frame;
  logic [`FRAME_ADDR_W-1:0]           addr;
  logic [7:0]                         rd_data;
  logic [7:0]                         status;

  modport rx (
    output frame_done,
    output frame,
    output addr,
    input  rd_data,
    input  status
  );

  modport bank (
    input  frame_done,
    input  frame,
    input  addr,
    output rd_data,
    output status
  );
endinterface

// file: src/spi_frame_rx.sv
// spi slave shifter: samples the pins on the system clock, lsb first
// assumes sclk idles low, mosi sampled on falling edge, miso shifted on rising
`timescale 1ns/1ns
`include "mode_supply_ctrl_map.svh"

module spi_frame_rx (
  input  wire logic   clk_sys_i,
  input  wire logic   reset_i,
  input  wire logic   spi_sclk_i,
  input  wire logic   spi_cs_n_i,
  input  wire logic   spi_mosi_i,
  output logic        spi_miso_o,
  output logic        spi_miso_oe_o,
  spi_frame_if.rx     fr
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclk_reg;
  logic [2:0] cs_n_reg;
  logic [1:0] mosi_reg;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sclk_reg <= 3'h0;
      cs_n_reg <= 3'h7;
      mosi_reg <= 2'h0;
    end else begin
      sclk_reg <= {sclk_reg[1:0], spi_sclk_i};
      cs_n_reg <= {cs_n_reg[1:0], spi_cs_n_i};
      mosi_reg <= {mosi_reg[0], spi_mosi_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_start;
  logic cs_end;
  logic active;

  assign sclk_rise = sclk_reg[1] & ~sclk_reg[2];
  assign sclk_fall = ~sclk_reg[1] & sclk_reg[2];
  assign cs_start  = ~cs_n_reg[1] & cs_n_reg[2];
  assign cs_end    = cs_n_reg[1] & ~cs_n_reg[2];
  assign active    = ~cs_n_reg[1];

  // ****************************************
  // shifters
  // ****************************************
  mode_supply_ctrl_pkg::frame_t rx_reg;
  logic [15:0]                  tx_reg;
  logic [4:0]                   cnt_reg;
  logic                         load_reg;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_reg  <= 16'h0000;
      cnt_reg <= 5'h00;
    end else if (cs_start) begin
      cnt_reg <= 5'h00;
    end else if (active && sclk_fall) begin
      rx_reg  <= {mosi_reg[1], rx_reg[15:1]};
      if (cnt_reg != 5'h1f)
        cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // address byte complete: second byte goes out with the contents held now
  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      load_reg <= 1'b0;
    else
      load_reg <= active && sclk_fall && (cnt_reg == `FRAME_BYTE_BITS - 5'h01);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_reg        <= 16'h0000;
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= active;
      if (cs_start) begin
        tx_reg <= {8'h00, fr.status};
      end else if (load_reg) begin
        tx_reg[7:0] <= fr.rd_data;
      end else if (active && sclk_rise) begin
        spi_miso_o <= tx_reg[0];
        tx_reg     <= {1'b0, tx_reg[15:1]};
      end
    end
  end

  // ****************************************
  // frame hand-off
  // ****************************************
  // frames that are not exactly sixteen bits long are dropped
  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      fr.frame_done <= 1'b0;
    else
      fr.frame_done <= cs_end && (cnt_reg == `FRAME_BITS);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      fr.frame <= 16'h0000;
    else if (cs_end)
      fr.frame <= rx_reg;
  end

  assign fr.addr = rx_reg[14:8];

endmodule // spi_frame_rx

// file: src/mode_supply_ctrl.sv
// mode and supply control register bank behind a 16-bit spi slave
// assumes the host is the spi master; events arrive from logic on clk_sys_i
`timescale 1ns/1ns
`include "mode_supply_ctrl_map.svh"

module mode_supply_ctrl (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o,
  input  wire logic       restart_i,
  input  wire logic       overtemperature_event_i,
  input  wire logic       main_overvoltage_i,
  input  wire logic       softreset_pin_trigger_cfg_i,
  output logic [1:0]      mode_o,
  output logic            third_regulator_enable_o,
  output logic [1:0]      second_regulator_mode_o,
  output logic [1:0]      main_reset_threshold_sel_o,
  output logic            main_overvoltage_flag_o,
  output logic            ov_restart_req_o,
  output logic            soft_reset_o,
  output logic            reset_output_pin_o
);

  // ****************************************
  // frame receiver
  // ****************************************
  spi_frame_if fr ();

  spi_frame_rx u_rx (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .spi_sclk_i    (spi_sclk_i),
    .spi_cs_n_i    (spi_cs_n_i),
    .spi_mosi_i    (spi_mosi_i),
    .spi_miso_o    (spi_miso_o),
    .spi_miso_oe_o (spi_miso_oe_o),
    .fr            (fr.rx)
  );

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hits_ctrl(input logic [`FRAME_ADDR_W-1:0] a);
    hits_ctrl = (a == `MS_CTRL_ADDR);
  endfunction

  mode_supply_ctrl_pkg::ms_ctrl_t ctrl_reg;
  logic [6:0]                     wr_addr;
  logic [7:0]                     wr_data;
  logic                           wr_en;
  logic                           soft_rst;

  assign wr_addr  = fr.frame[6:0];
  assign wr_data  = fr.frame[15:8];
  assign wr_en    = fr.frame_done && fr.frame[`FRAME_RW_BIT] && hits_ctrl(wr_addr);
  assign soft_rst = wr_en && (wr_data[`MODE_HI:`MODE_LO] == `MODE_SOFT_RESET);

  // reads of unimplemented addresses answer zero; no reserved bits live here
  assign fr.rd_data = hits_ctrl(fr.addr) ? ctrl_reg : 8'h00;
  assign fr.status  = {7'h00, main_overvoltage_flag_o};

  // ****************************************
  // control register
  // ****************************************
  // hardware events are applied after a normal host write so they win that tie; a soft reset write wins over them
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || soft_rst) begin
      ctrl_reg <= `MS_CTRL_RESET;
    end else begin
      if (wr_en) begin
        ctrl_reg <= wr_data;
        if (ctrl_reg.mode == `MODE_STOP && wr_data[`MODE_HI:`MODE_LO] == `MODE_SLEEP)
          ctrl_reg.mode <= `MODE_STOP;
      end
      if (overtemperature_event_i)
        ctrl_reg.second_regulator_mode <= `SECOND_REG_OFF;
      if (restart_i)
        ctrl_reg <= ctrl_reg & `MS_CTRL_RESTART_KEEP;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_o                     <= `MODE_NORMAL;
      third_regulator_enable_o   <= 1'b0;
      second_regulator_mode_o    <= `SECOND_REG_OFF;
      main_reset_threshold_sel_o <= 2'h0;
    end else begin
      mode_o                     <= ctrl_reg.mode;
      third_regulator_enable_o   <= ctrl_reg.third_regulator_enable;
      second_regulator_mode_o    <= ctrl_reg.second_regulator_mode;
      main_reset_threshold_sel_o <= ctrl_reg.main_reset_threshold_sel;
    end
  end

  // flag cleared only by reset or a soft reset write; no other host write clears it in this bank
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || soft_rst)
      main_overvoltage_flag_o <= 1'b0;
    else if (main_overvoltage_i)
      main_overvoltage_flag_o <= 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      ov_restart_req_o <= 1'b0;
    else
      ov_restart_req_o <= main_overvoltage_i && ctrl_reg.main_overvoltage_restart_en;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      soft_reset_o       <= 1'b0;
      reset_output_pin_o <= 1'b0;
    end else begin
      soft_reset_o       <= soft_rst;
      reset_output_pin_o <= soft_rst && !softreset_pin_trigger_cfg_i;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic quiet;
  assign quiet = !restart_i && !overtemperature_event_i;

  property p_reset_value;
    // reset is the antecedent here, so the default disable would make this check empty
    @(posedge clk_sys_i) disable iff (1'b0) reset_i |=> (ctrl_reg == `MS_CTRL_RESET) ##1 (mode_o == `MODE_NORMAL);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

  property p_restart;
    restart_i && !soft_rst |=> ctrl_reg == ($past(ctrl_reg) & `MS_CTRL_RESTART_KEEP);
  endproperty
  a_restart: assert property (p_restart) else $error("restart value wrong");

  property p_read_only;
    fr.frame_done && !fr.frame[`FRAME_RW_BIT] && quiet |=> $stable(ctrl_reg);
  endproperty
  a_read_only: assert property (p_read_only) else $error("read changed register");

  property p_write;
    wr_en && quiet && wr_data[7:6] == `MODE_NORMAL |=> ctrl_reg == $past(wr_data);
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_unmapped;
    fr.frame_done && !hits_ctrl(wr_addr) && quiet |=> $stable(ctrl_reg);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed register");

  property p_soft_reset;
    soft_rst |=> ctrl_reg == `MS_CTRL_RESET && soft_reset_o
             && reset_output_pin_o == !$past(softreset_pin_trigger_cfg_i);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not executed");

  property p_stop_sleep;
    wr_en && quiet && ctrl_reg.mode == `MODE_STOP && wr_data[7:6] == `MODE_SLEEP |=> ctrl_reg.mode == `MODE_STOP;
  endproperty
  a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep accepted");

  property p_ot;
    overtemperature_event_i && !soft_rst |=> ctrl_reg.second_regulator_mode == `SECOND_REG_OFF
                                         ##1 second_regulator_mode_o == `SECOND_REG_OFF;
  endproperty
  a_ot: assert property (p_ot) else $error("second regulator not forced off");

  property p_ov;
    main_overvoltage_i && !soft_rst |=> main_overvoltage_flag_o
                                     && ov_restart_req_o == $past(ctrl_reg.main_overvoltage_restart_en);
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage reaction wrong");

  property p_hold;
    !fr.frame_done && quiet |=> $stable(ctrl_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without cause");

  property p_outputs;
    1'b1 |=> main_reset_threshold_sel_o == $past(ctrl_reg.main_reset_threshold_sel)
             && third_regulator_enable_o == $past(ctrl_reg.third_regulator_enable)
             && mode_o == $past(ctrl_reg.mode)
             && second_regulator_mode_o == $past(ctrl_reg.second_regulator_mode);
  endproperty
  a_outputs: assert property (p_outputs) else $error("outputs do not follow register");

  // ****************************************
  // field and event checks
  // ****************************************
  property p_write_mode;
    wr_en && quiet && wr_data[7:6] != `MODE_SOFT_RESET
      && !(ctrl_reg.mode == `MODE_STOP && wr_data[7:6] == `MODE_SLEEP) |=> ctrl_reg == $past(wr_data);
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("mode write not stored");

  property p_stop_sleep_fields;
    wr_en && quiet && ctrl_reg.mode == `MODE_STOP && wr_data[7:6] == `MODE_SLEEP
      |=> ctrl_reg[5:0] == $past(wr_data[5:0]);
  endproperty
  a_stop_sleep_fields: assert property (p_stop_sleep_fields) else $error("refused write lost other fields");

  property p_mode_legal;
    ctrl_reg.mode != `MODE_SOFT_RESET;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("soft reset code left in mode field");

  property p_restart_fields;
    restart_i && !soft_rst
      |=> ctrl_reg.mode == `MODE_NORMAL && ctrl_reg.second_regulator_mode == `SECOND_REG_OFF
          && !ctrl_reg.main_overvoltage_restart_en;
  endproperty
  a_restart_fields: assert property (p_restart_fields) else $error("restart fields not cleared");

  // overtemperature may touch only the second regulator field
  property p_ot_only;
    overtemperature_event_i && !restart_i && !fr.frame_done
      |=> ctrl_reg.mode == $past(ctrl_reg.mode)
          && ctrl_reg.third_regulator_enable == $past(ctrl_reg.third_regulator_enable)
          && ctrl_reg.main_overvoltage_restart_en == $past(ctrl_reg.main_overvoltage_restart_en)
          && ctrl_reg.main_reset_threshold_sel == $past(ctrl_reg.main_reset_threshold_sel);
  endproperty
  a_ot_only: assert property (p_ot_only) else $error("overtemperature changed other fields");

  property p_host_only_bits;
    !wr_en |=> $stable(ctrl_reg.main_reset_threshold_sel) && $stable(ctrl_reg.third_regulator_enable);
  endproperty
  a_host_only_bits: assert property (p_host_only_bits) else $error("kept field changed by hardware");

  property p_flag_sticky;
    main_overvoltage_flag_o && !soft_rst |=> main_overvoltage_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overvoltage flag lost");

  property p_soft_flag;
    soft_rst |=> !main_overvoltage_flag_o;
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("soft reset kept overvoltage flag");

  property p_ov_quiet;
    !main_overvoltage_i |=> !ov_restart_req_o;
  endproperty
  a_ov_quiet: assert property (p_ov_quiet) else $error("restart request without overvoltage");

  property p_pulse_quiet;
    !soft_rst |=> !soft_reset_o && !reset_output_pin_o;
  endproperty
  a_pulse_quiet: assert property (p_pulse_quiet) else $error("soft reset pulse without request");

  // ****************************************
  // link checks
  // ****************************************
  // two synchroniser stages plus the registered enable give three cycles
  property p_oe_on;
    $fell(spi_cs_n_i) |-> ##3 spi_miso_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out not driven in frame");

  property p_oe_off;
    $rose(spi_cs_n_i) |-> ##3 !spi_miso_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven after frame");

  property p_done_pulse;
    fr.frame_done |=> !fr.frame_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame taken twice");

  c_write:   cover property (wr_en && !soft_rst);
  c_soft:    cover property (soft_rst);
  c_restart: cover property (restart_i);
  c_refuse:  cover property (wr_en && ctrl_reg.mode == `MODE_STOP && wr_data[7:6] == `MODE_SLEEP);
  c_ot:      cover property (overtemperature_event_i);

endmodule // mode_supply_ctrl

// file: tb/spi_host_model.sv
// behavioural spi master standing in for the host controller
// assumes the bench hands it one frame at a time and waits for done_o
`timescale 1ns/1ns

module spi_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        start_i,
  input  wire logic [15:0] frame_i,
  input  wire logic [4:0]  nbits_i,
  input  wire logic        miso_i,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             mosi_o,
  output logic [15:0]      rx_o,
  output logic             done_o
);
  // ****************************************
  // frame engine
  // ****************************************
  // half period of 8 clocks gives the 160 ns link clock; sclk stands low between frames
  int i;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    rx_o = 16'h0000;
    done_o = 1'b0;
  end

  always begin
    @(posedge clk_sys_i);
    if (start_i === 1'b1) begin
      cs_n_o <= 1'b0;
      mosi_o <= frame_i[0];
      rx_o <= 16'h0000;
      repeat (8) @(posedge clk_sys_i);
      for (i = 0; i < nbits_i; i++) begin
        sclk_o <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rx_o[i] <= miso_i;
        sclk_o <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        // past the frame the line toggles so a stale bit is never taken for data
        mosi_o <= (i < 15) ? frame_i[i + 1] : ~mosi_o;
      end
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      done_o <= 1'b1;
      @(posedge clk_sys_i);
      done_o <= 1'b0;
    end
  end
endmodule // spi_host_model

// file: tb/testbench.sv
// self-checking bench for the mode and supply control register bank
// assumes the host model drives the spi pins; events are driven here on clk_sys_i
`timescale 1ns/1ns

module testbench;
  // ****************************************
  // wiring
  // ****************************************
  logic        clk_sys_i, reset_i, start, restart_i, ot_i, ov_i, cfg_i;
  logic [15:0] frame, rx;
  logic [4:0]  nbits;
  logic        sclk, cs_n, mosi, miso, miso_oe, done;
  logic [1:0]  mode_o, second_o, thresh_o;
  logic        third_o, flag_o, ovreq_o, sr_o, ro_o;
  int          fails, total_checks, m, flag, n_sr, n_ro, n_ov;

  mode_supply_ctrl i_mode_supply_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .restart_i(restart_i),
    .overtemperature_event_i(ot_i), .main_overvoltage_i(ov_i), .softreset_pin_trigger_cfg_i(cfg_i),
    .mode_o(mode_o), .third_regulator_enable_o(third_o), .second_regulator_mode_o(second_o),
    .main_reset_threshold_sel_o(thresh_o), .main_overvoltage_flag_o(flag_o), .ov_restart_req_o(ovreq_o),
    .soft_reset_o(sr_o), .reset_output_pin_o(ro_o));

  spi_host_model i_spi_host_model (.clk_sys_i(clk_sys_i), .start_i(start), .frame_i(frame), .nbits_i(nbits),
    .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .rx_o(rx), .done_o(done));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // pulses last one cycle, so they are counted rather than sampled at a guessed moment
  always @(posedge clk_sys_i) begin
    if (sr_o === 1'b1) n_sr++;
    if (ro_o === 1'b1) n_ro++;
    if (ovreq_o === 1'b1) n_ov++;
  end

  // ****************************************
  // tasks and model
  // ****************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic xfer(logic [15:0] f, logic [4:0] nb);
    int k;
    frame <= f;
    nbits <= nb;
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(6);
    check("oe active", miso_oe, 1'b1);
    for (k = 0; k < 2000 && done !== 1'b1; k++) tick(1);
    if (done !== 1'b1) begin
      fails++;
      final_report();
    end
    tick(6);
    check("oe idle", miso_oe, 1'b0);
  endtask

  function automatic int wmodel(int d);
    if (((m >> 6) & 2'h3) == 2'h2 && ((d >> 6) & 2'h3) == 2'h1) d = (d & 8'h3f) | 8'h80;
    if (((d >> 6) & 2'h3) == 2'h3) begin
      flag = 0;
      return 0;
    end
    return d & 8'hff;
  endfunction

  task automatic outs;
    check("mode", mode_o, (m >> 6) & 2'h3);
    check("third", third_o, (m >> 5) & 1'h1);
    check("second", second_o, (m >> 3) & 2'h3);
    check("thresh", thresh_o, m & 2'h3);
    check("ovflag", flag_o, flag);
  endtask

  task automatic wr(int a, int d);
    logic [7:0] dv;
    logic [6:0] av;
    dv = d;
    av = a;
    xfer({dv, 1'b1, av}, 5'h10);
    check("old contents", rx[15:8], (a == 1) ? m : 0);
    check("status", rx[7:0], flag);
    if (a == 1) m = wmodel(d);
    outs();
  endtask

  task automatic rd(int a);
    logic [6:0] av;
    logic [7:0] junk;
    av = a;
    junk = $urandom;
    xfer({junk, 1'b0, av}, 5'h10);
    check("read data", rx[15:8], (a == 1) ? m : 0);
    outs();
  endtask

  task automatic ev(int which);
    if (which == 0) restart_i <= 1'b1;
    else if (which == 1) ot_i <= 1'b1;
    else ov_i <= 1'b1;
    tick(1);
    restart_i <= 1'b0;
    ot_i <= 1'b0;
    ov_i <= 1'b0;
    tick(4);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int i;
    int d;
    int b_sr;
    int b_ro;
    int b_ov;
    {start, restart_i, ot_i, ov_i, cfg_i} = 5'h00;
    frame = 16'h0000;
    nbits = 5'h00;
    reset_i = 1'b1;
    {fails, total_checks, m, flag} = '0;
    void'($urandom(32'h77e4));
    tick(10);
    reset_i <= 1'b0;
    tick(2);
    outs();
    rd(1);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      d = $urandom & 8'hff;
      if (((d >> 6) & 2'h3) == 2'h3) d = d ^ 8'h40;
      wr(1, d);
    end
    wr(1, 8'h80);
    wr(1, 8'h5b);
    rd(1);
    $display("test writes done");
    wr(7'h05, 8'hff);
    rd(1);
    rd(7'h05);
    $display("test unmapped done");
    wr(1, 8'hbf);
    ev(0);
    m = m & 8'h23;
    outs();
    rd(1);
    wr(1, 8'h18);
    ev(1);
    m = m & 8'he7;
    outs();
    $display("test restart done");
    wr(1, 8'h04);
    b_ov = n_ov;
    ev(2);
    flag = 1;
    check("ov request", n_ov - b_ov, 1);
    wr(1, 8'h00);
    ev(2);
    check("ov request", n_ov - b_ov, 1);
    rd(1);
    $display("test overvoltage done");
    b_sr = n_sr;
    b_ro = n_ro;
    wr(1, 8'hc5);
    check("soft reset", n_sr - b_sr, 1);
    check("reset pin", n_ro - b_ro, 1);
    cfg_i <= 1'b1;
    wr(1, 8'h2a);
    wr(1, 8'hff);
    check("soft reset", n_sr - b_sr, 2);
    check("reset pin", n_ro - b_ro, 1);
    $display("test soft reset done");
    wr(1, 8'h2a);
    xfer({8'hd5, 1'b1, 7'h01}, 5'h0f);
    outs();
    reset_i <= 1'b1;
    tick(3);
    reset_i <= 1'b0;
    tick(2);
    m = 0;
    flag = 0;
    outs();
    rd(1);
    $display("test short frame and reset done");
    final_report();
  end
endmodule // testbench
